// >>> common/rff_pkg.sv
/*
  Package for the regulator fault flag bank: register offsets, flag bit
  positions, filter timing and the packed monitor carrier.
  Assumes a 250 MHz core clock and a 32-bit Avalon-MM register bus.
*/
`default_nettype none
package rff_pkg;
  // Flag bit positions inside the flag word
  localparam int FLAG_W              = 12;
  localparam int B_AUX_RAIL_LOW      = 0;
  localparam int B_AUX_RAIL_OC       = 1;
  localparam int B_XCVR_RAIL_OT      = 2;
  localparam int B_XCVR_RAIL_UV      = 3;
  localparam int B_XCVR_RAIL_OC      = 4;
  localparam int B_SENSE_INPUT_LOW   = 5;
  localparam int B_SUPPLY_UV         = 6;
  localparam int B_MAIN_OC_RUN       = 7;
  localparam int B_MAIN_OC_SLEEP_ON  = 8;
  localparam int B_MAIN_THERMAL_OFF  = 9;
  localparam int B_SHORT_RESET_PULSE = 10;
  localparam int B_BATTERY_FAIL      = 11;

  // Register byte offsets
  localparam logic [3:0] OFS_FLAGS   = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
  localparam logic [3:0] OFS_IRQ_EN  = 4'hC;

  // Reset values
  localparam logic [FLAG_W-1:0] FLAGS_RST  = 12'h000;
  localparam logic [FLAG_W-1:0] IRQ_EN_RST = 12'h000;

  // Filter and pulse timing
  localparam int CLK_MHZ         = 250;
  localparam int FILTER_US       = 100;
  localparam int FILTER_CYCLES   = FILTER_US * CLK_MHZ;
  localparam int RST_PULSE_MS    = 100;
  localparam int RST_PULSE_CYCLES = RST_PULSE_MS * 1000 * CLK_MHZ;

  // Raw monitor conditions, one bit per flag
  typedef struct packed {
    logic battery_fail;
    logic reset_pin_low;
    logic main_thermal_off;
    logic main_oc_sleep_on;
    logic main_oc_run;
    logic supply_uv;
    logic sense_input_low;
    logic xcvr_rail_oc;
    logic xcvr_rail_uv;
    logic xcvr_rail_ot;
    logic aux_rail_oc;
    logic aux_rail_low;
  } rff_mon_t;
endpackage
`default_nettype wire

// >>> logic/rff_top.sv
/*
  Latched fault flags for the supply monitors, read over Avalon-MM.
  Monitor inputs come from analog comparators outside the clock domain and
  are synchronised here. Mode inputs come from logic on the same clock.
*/
// Functional notes
// - Aux low flag after 100 us filter
// - Aux overcurrent flag after 100 us filter
// - Transceiver rail overtemp flag while sensor hot
// - Transceiver rail undervoltage after 100 us
// - Transceiver rail overcurrent after 100 us
// - Sense input low after 100 us
// - Supply undervoltage after 100 us
// - Main rail overcurrent in run mode, 100 us
// - Sleep-on overcurrent flag, 100 us, separate
// - Thermal-off flag while main rail shut down
// - Reset pin low shorter than 100 ms flagged
// - Battery fail flag below threshold
`default_nettype none
module rff_top #(
  parameter int FILTER_CYCLES    = rff_pkg::FILTER_CYCLES,
  parameter int RST_PULSE_CYCLES = rff_pkg::RST_PULSE_CYCLES
) (
  input  wire logic                      CLK,
  input  wire logic                      RST_B,
  input  wire logic                      CE,
  input  wire rff_pkg::rff_mon_t         MON,
  input  wire logic                      RUN_MODE,
  input  wire logic                      LOW_POWER_MAIN_RAIL_ON,
  input  wire logic [3:0]                AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [31:0]               AVS_WRITEDATA,
  input  wire logic [3:0]                AVS_BYTEENABLE,
  output logic      [31:0]               AVS_READDATA,
  output logic                           AVS_WAITREQUEST,
  output logic                           IRQ
);
  localparam int FW = rff_pkg::FLAG_W;
  localparam int CW = 32;

  // Elaboration check: both counters are CW bits wide and must reach their limit
  if (FILTER_CYCLES < 1 || FILTER_CYCLES > 2**30 ||
      RST_PULSE_CYCLES < 2 || RST_PULSE_CYCLES > 2**30)
  begin : g_bad_timing
    $error("rff_top: timing parameters out of range");
  end

  // Saturating count of a level; any drop of the level restarts it from zero
  function automatic logic [CW-1:0] sat_inc(input logic          level,
                                            input logic [CW-1:0] cnt,
                                            input logic [CW-1:0] lim);
    if (!level)
      return '0;
    else if (cnt < lim)
      return cnt + 1'b1;
    else
      return cnt;
  endfunction

  // Three-stage synchronisers; stage 1 feeds only stage 2
  logic [FW-1:0] s1_reg;
  logic [FW-1:0] s2_reg;
  logic [FW-1:0] s3_reg;
  logic [FW-1:0] mon_reg;
  wire  [FW-1:0] mon_next;
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      mon_reg <= '0;
    end
    else if (CE)
    begin
      s1_reg  <= MON;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      mon_reg <= mon_next;
    end
  end

  // A change is accepted once stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < FW; g++)
    begin : g_agree
      assign mon_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : mon_reg[g];
    end
  endgenerate

  // Qualified raw conditions; the two main-rail overcurrent flags depend on mode
  logic [FW-1:0] cond;
  always_comb
  begin
    cond = mon_reg;
    cond[rff_pkg::B_MAIN_OC_RUN]      = mon_reg[rff_pkg::B_MAIN_OC_RUN] & RUN_MODE;
    cond[rff_pkg::B_MAIN_OC_SLEEP_ON] = mon_reg[rff_pkg::B_MAIN_OC_SLEEP_ON]
                                        & LOW_POWER_MAIN_RAIL_ON;
  end

  // Flags with a persistence filter; the others set directly, except the reset-pulse flag
  localparam logic [FW-1:0] FILTERED = 12'h1FB;

  logic [CW-1:0] filt_cnt_reg [FW];
  wire  [CW-1:0] filt_cnt_next [FW];
  wire  [FW-1:0] set_ev;
  generate
    for (g = 0; g < FW; g++)
    begin : g_filt
      if (FILTERED[g])
      begin : g_f
        // Counter restarts whenever the condition drops out
        assign filt_cnt_next[g] = sat_inc(cond[g], filt_cnt_reg[g],
                                          CW'(FILTER_CYCLES));
        // Set after the condition has held for the full filter time
        assign set_ev[g] = cond[g] && (filt_cnt_reg[g] >= CW'(FILTER_CYCLES) - 1);
      end
      else
      begin : g_d
        assign filt_cnt_next[g] = '0;
        if (g != rff_pkg::B_SHORT_RESET_PULSE)
        begin : g_lvl
          assign set_ev[g] = cond[g];
        end
      end
    end
  endgenerate

  // All persistence counters in one bank, so each has a single writer
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      filt_cnt_reg <= '{default: '0};
    else if (CE)
      filt_cnt_reg <= filt_cnt_next;
  end

  // Reset-pin pulse width: flag a low pulse that ends before 100 ms.
  // Trade-off: the flag is set when the pulse ends, so a pulse that is still
  // low is not yet classified.
  logic [CW-1:0] pulse_cnt_reg;
  logic          pin_low_d_reg;
  wire           pin_low   = cond[rff_pkg::B_SHORT_RESET_PULSE];
  wire           pulse_end = pin_low_d_reg && !pin_low;
  assign set_ev[rff_pkg::B_SHORT_RESET_PULSE] =
    pulse_end && (pulse_cnt_reg < CW'(RST_PULSE_CYCLES));
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pulse_cnt_reg <= '0;
      pin_low_d_reg <= 1'b0;
    end
    else if (CE)
    begin
      pin_low_d_reg <= pin_low;
      pulse_cnt_reg <= sat_inc(pin_low, pulse_cnt_reg, CW'(RST_PULSE_CYCLES));
    end
  end

  // Bus handshake. A read waits one cycle so that its data leaves a flip-flop;
  // writes answer at once. Nothing is taken while the clock enable is low.
  logic        rd_ack_reg;
  logic [31:0] rdata_reg;
  wire         rd_take = AVS_READ && !rd_ack_reg;
  assign AVS_WAITREQUEST = !CE || rd_take;
  wire         bus_go   = !AVS_WAITREQUEST;
  wire         rd_flags = AVS_READ && bus_go && (AVS_ADDRESS == rff_pkg::OFS_FLAGS);
  wire         wr_clr   = AVS_WRITE && bus_go && (AVS_ADDRESS == rff_pkg::OFS_IRQ_CLR);
  wire         wr_en    = AVS_WRITE && bus_go && (AVS_ADDRESS == rff_pkg::OFS_IRQ_EN);

  // Latched flags: set wins; a read clears only bits whose fault has ended
  logic [FW-1:0] flags_reg;
  logic [FW-1:0] flags_next;
  logic [FW-1:0] clr_mask;
  // Only bits the host was shown may clear: a flag set during the read's
  // wait cycle survives until the next read
  assign clr_mask   = rd_flags ? (~cond & rdata_reg[FW-1:0]) : '0;
  assign flags_next = set_ev | (flags_reg & ~clr_mask);

  // Interrupt status records each new flag rising; cleared by write-one
  logic [FW-1:0] status_reg;
  logic [FW-1:0] irq_en_reg;
  logic [FW-1:0] rise;
  logic [FW-1:0] status_next;
  logic [FW-1:0] wr_clr_bits;
  assign rise        = set_ev & ~flags_reg;
  assign wr_clr_bits = wr_clr ? AVS_WRITEDATA[FW-1:0] : '0;
  assign status_next = rise | (status_reg & ~wr_clr_bits);
  assign IRQ         = |(status_reg & irq_en_reg);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flags_reg  <= rff_pkg::FLAGS_RST;
      status_reg <= '0;
      irq_en_reg <= rff_pkg::IRQ_EN_RST;
    end
    else if (CE)
    begin
      flags_reg  <= flags_next;
      status_reg <= status_next;
      if (wr_en && AVS_BYTEENABLE[0])
        irq_en_reg[7:0] <= AVS_WRITEDATA[7:0];
      if (wr_en && AVS_BYTEENABLE[1])
        irq_en_reg[FW-1:8] <= AVS_WRITEDATA[FW-1:8];
    end
  end

  // Read data: flags show state before the read's own clear
  logic [31:0] rdata;
  always_comb
  begin
    rdata = '0;
    case (AVS_ADDRESS)
      rff_pkg::OFS_FLAGS:  rdata[FW-1:0] = flags_reg;
      rff_pkg::OFS_STATUS: rdata[FW-1:0] = status_reg;
      rff_pkg::OFS_IRQ_EN: rdata[FW-1:0] = irq_en_reg;
      default:             rdata = '0;
    endcase
  end

  // Read data register: loaded in the waited cycle, shown in the answering one
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rd_ack_reg <= 1'b0;
      rdata_reg  <= '0;
    end
    else if (CE)
    begin
      rd_ack_reg <= rd_take;
      rdata_reg  <= rd_take ? rdata : '0;
    end
  end
  assign AVS_READDATA = rdata_reg;

  // Checks
  sequence s_hold_filter;
    cond[rff_pkg::B_AUX_RAIL_LOW] [*8];
  endsequence
  property p_set_wins;
    @(posedge CLK) disable iff (!RST_B)
      CE && set_ev[rff_pkg::B_SUPPLY_UV] |=> flags_reg[rff_pkg::B_SUPPLY_UV];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");
  property p_read_keeps;
    @(posedge CLK) disable iff (!RST_B)
      CE && rd_flags && cond[rff_pkg::B_AUX_RAIL_LOW] && flags_reg[rff_pkg::B_AUX_RAIL_LOW]
      |=> flags_reg[rff_pkg::B_AUX_RAIL_LOW];
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("flag lost");
  property p_read_clears;
    @(posedge CLK) disable iff (!RST_B)
      CE && rd_flags && rdata_reg[rff_pkg::B_XCVR_RAIL_OT] && !cond[rff_pkg::B_XCVR_RAIL_OT]
      && !set_ev[rff_pkg::B_XCVR_RAIL_OT]
      |=> !flags_reg[rff_pkg::B_XCVR_RAIL_OT];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("no clear");
  property p_no_early;
    @(posedge CLK) disable iff (!RST_B)
      !cond[rff_pkg::B_AUX_RAIL_LOW] ##1 s_hold_filter |-> FILTER_CYCLES <= 8 ||
      !set_ev[rff_pkg::B_AUX_RAIL_LOW];
  endproperty
  a_no_early: assert property (p_no_early) else $error("early set");
  property p_restart;
    @(posedge CLK) disable iff (!RST_B)
      CE && !cond[rff_pkg::B_SENSE_INPUT_LOW] |=> filt_cnt_reg[rff_pkg::B_SENSE_INPUT_LOW] == 0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_mode_gate;
    @(posedge CLK) disable iff (!RST_B)
      !RUN_MODE |-> !set_ev[rff_pkg::B_MAIN_OC_RUN];
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("mode gate");
  property p_sleep_gate;
    @(posedge CLK) disable iff (!RST_B)
      !LOW_POWER_MAIN_RAIL_ON |-> !set_ev[rff_pkg::B_MAIN_OC_SLEEP_ON];
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep gate");
  property p_pulse;
    @(posedge CLK) disable iff (!RST_B)
      CE && set_ev[rff_pkg::B_SHORT_RESET_PULSE] |-> $past(pin_low)
      ##1 flags_reg[rff_pkg::B_SHORT_RESET_PULSE];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse flag");
  property p_irq;
    @(posedge CLK) disable iff (!RST_B)
      CE && (|rise) |=> (|status_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("status lost");
  // A waited read is answered in the next enabled cycle with the flags it saw
  sequence s_rd_waited;
    CE && AVS_READ && AVS_WAITREQUEST;
  endsequence
  property p_rd_answer;
    @(posedge CLK) disable iff (!RST_B)
      s_rd_waited |=> !CE || !AVS_WAITREQUEST;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_data;
    @(posedge CLK) disable iff (!RST_B)
      s_rd_waited ##1 (CE && rd_flags) |-> AVS_READDATA[FW-1:0] == $past(flags_reg);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
endmodule // rff_top
`default_nettype wire

// >>> bench/rff_host.sv
/*
  Host model: Avalon-MM master that reads and writes the flag bank.
  Assumes one caller at a time and a single clock shared with the slave.
*/
`default_nettype none
module rff_host (
  input  wire logic        clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  output logic             timed_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus at time zero; full word lanes on every access
  initial
  begin
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    timed_out      = 1'b0;
  end

  // One access; the request stands until the edge at which waitrequest is low.
  // Slave outputs are looked at on the falling edge, where they have settled,
  // and belong to the rising edge that follows.
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
    int   n;
    logic done;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    n    = 0;
    done = 1'b0;
    rd   = 32'h0;
    while (!done && n < 50)
    begin
      @(negedge clk);
      done = (avs_waitrequest === 1'b0);
      rd   = avs_readdata;
      @(posedge clk);
      n++;
    end
    if (!done)
      timed_out <= 1'b1;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Idle bus shows inverted values so a stale word never reads as valid
    avs_address   <= ~a;
    avs_writedata <= ~wd;
  endtask
endmodule // rff_host
`default_nettype wire

// >>> bench/regulator_fault_flags_test.sv
/*
  Self-checking bench for the fault flag bank with shortened filter counts.
  Assumes the flag, status, clear and enable offsets of the package.
*/
`default_nettype none
`define CHK(nm, exp, got) \
  begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module regulator_fault_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [3:0] b; logic [7:0] hs; logic [7:0] hn; } rff_row_t;
  // Bit, hold that must set it, hold that must not (0 skips); filter is 10
  localparam rff_row_t ROWS [12] = '{
    '{4'h0, 8'h12, 8'h07}, '{4'h1, 8'h12, 8'h07}, '{4'h2, 8'h06, 8'h00},
    '{4'h3, 8'h12, 8'h07}, '{4'h4, 8'h12, 8'h07}, '{4'h5, 8'h12, 8'h07},
    '{4'h6, 8'h12, 8'h07}, '{4'h7, 8'h12, 8'h07}, '{4'h8, 8'h12, 8'h07},
    '{4'h9, 8'h06, 8'h00}, '{4'hA, 8'h14, 8'h3C}, '{4'hB, 8'h06, 8'h00}};
  logic clk = 1'b0, rst_b = 1'b0, run_mode = 1'b1, lp_on = 1'b1, irq, waitreq;
  logic rdv, wrv, tmo, ce = 1'b1;
  logic [11:0] mon = 12'h000;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, d;
  int          miscompares = 0, checks_done = 0;

  always #2 clk = ~clk;

  rff_top #(.FILTER_CYCLES(10), .RST_PULSE_CYCLES(50)) u_rff_top (
    .CLK(clk), .RST_B(rst_b), .CE(ce), .MON(rff_pkg::rff_mon_t'(mon)),
    .RUN_MODE(run_mode), .LOW_POWER_MAIN_RAIL_ON(lp_on), .AVS_ADDRESS(addr),
    .AVS_READ(rdv), .AVS_WRITE(wrv), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .IRQ(irq));
  rff_host u_rff_host (
    .clk(clk), .avs_readdata(rdata), .avs_waitrequest(waitreq), .avs_address(addr),
    .avs_read(rdv), .avs_write(wrv), .avs_writedata(wdata), .avs_byteenable(be),
    .timed_out(tmo));

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    u_rff_host.access(1'b0, a, 32'h0, v);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] x;
    u_rff_host.access(1'b1, a, v, x);
  endtask
  // Raise one monitor for a hold, drop it, repeat; then let the synchroniser settle
  task automatic fault(input int b, input int hold, input int times);
    for (int k = 0; k < times; k++)
    begin
      mon[b] <= 1'b1;
      repeat (hold) @(posedge clk);
      mon[b] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  // A hung handshake or a runaway run both end in the report
  always @(posedge tmo)
  begin
    miscompares++;
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    `CHK("irq in reset", 1'b0, irq)
    rst_b <= 1'b1;
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("flags reset", 32'h0, d)
    rd(rff_pkg::OFS_IRQ_EN, d);
    `CHK("enable reset", 32'h0, d)
    rd(4'h2, d);
    `CHK("unmapped", 32'h0, d)
    foreach (ROWS[i])
    begin
      fault(ROWS[i].b, ROWS[i].hs, 1);
      rd(rff_pkg::OFS_FLAGS, d);
      `CHK("flag set", 32'h1 << ROWS[i].b, d)
      rd(rff_pkg::OFS_FLAGS, d);
      `CHK("flag cleared", 32'h0, d)
      if (ROWS[i].hn != 8'h00)
      begin
        fault(ROWS[i].b, ROWS[i].hn, 2);
        rd(rff_pkg::OFS_FLAGS, d);
        `CHK("flag unqualified", 32'h0, d)
      end
    end
    // Status is sticky and ignores writes to its own offset
    wr(rff_pkg::OFS_STATUS, 32'h0);
    rd(rff_pkg::OFS_STATUS, d);
    `CHK("status", 32'h0000_0FFF, d)
    wr(rff_pkg::OFS_IRQ_CLR, 32'h0000_0FFF);
    wr(rff_pkg::OFS_IRQ_EN, 32'h0000_0001);
    rd(rff_pkg::OFS_STATUS, d);
    `CHK("status cleared", 32'h0, d)
    // Reads while the fault persists must not clear it
    mon[0] <= 1'b1;
    repeat (18) @(posedge clk);
    rd(rff_pkg::OFS_FLAGS, d);
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("flag held", 32'h1, d)
    mon[0] <= 1'b0;
    repeat (6) @(posedge clk);
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("flag ended", 32'h1, d)
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("flag gone", 32'h0, d)
    @(negedge clk);
    `CHK("irq raised", 1'b1, irq)
    wr(rff_pkg::OFS_IRQ_EN, 32'h0);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(rff_pkg::OFS_IRQ_EN, 32'h0000_0001);
    wr(rff_pkg::OFS_IRQ_CLR, 32'h0000_0001);
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    // Mode gating of the two main-rail overcurrent flags
    @(posedge clk);
    run_mode <= 1'b0;
    lp_on    <= 1'b0;
    fault(7, 18, 1);
    fault(8, 18, 1);
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("gated", 32'h0, d)
    // A frozen clock enable hides even a long fault
    ce <= 1'b0;
    fault(6, 30, 1);
    ce <= 1'b1;
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("frozen", 32'h0, d)
    // Second reset in mid-run wipes status
    fault(2, 6, 1);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd(rff_pkg::OFS_STATUS, d);
    `CHK("status after reset", 32'h0, d)
    rd(rff_pkg::OFS_FLAGS, d);
    `CHK("flags after reset", 32'h0, d)
    final_report();
  end
endmodule // regulator_fault_flags_test
`default_nettype wire
